//--- mmc_mode_map.svh
`ifndef MMC_MODE_MAP_SVH
`define MMC_MODE_MAP_SVH

// register indices; the byte address on the bus is four times the index
`define MMC_IDX_CFG_FIRST   8'h96
`define MMC_IDX_CFG_SECOND  8'h97
`define MMC_IDX_CFG_THIRD   8'h98

// reset values of the three configuration words
`define MMC_RST_CFG_FIRST   24'h000000
`define MMC_RST_CFG_SECOND  24'h000000
`define MMC_RST_CFG_THIRD   24'h000000

// writable bits; every other bit is reserved and holds zero
`define MMC_WMASK_FIRST     24'hC00000
`define MMC_WMASK_SECOND    24'hCFC3FC
`define MMC_WMASK_THIRD     24'h0003F0

// first configuration word
`define MMC_BIT_LEAK_HPF    22
`define MMC_BIT_WAVE_LEAK   23
// second configuration word: selector low bits, ic ib ia in va vb vc
`define MMC_POS_SEL_IC      2
`define MMC_POS_SEL_IB      4
`define MMC_POS_SEL_IA      6
`define MMC_POS_SEL_IN      8
`define MMC_POS_SEL_VA      14
`define MMC_POS_SEL_VB      16
`define MMC_POS_SEL_VC      18
`define MMC_BIT_REFRESH     22
`define MMC_BIT_FREQ        23
// third configuration word
`define MMC_BIT_ISUM_SEL    4
`define MMC_POS_PERIOD      5
`define MMC_BIT_APPARENT_POWER_METHOD_SELECT      7
`define MMC_BIT_ADD_SEL     8
`define MMC_BIT_PULSE_EN    9

// timing
`define MMC_CLK_HZ          100000000
`define MMC_REFRESH_SHORT_MS 500
`define MMC_REFRESH_LONG_MS  1000

`endif

//--- mmc_pkg.sv
package mmc_pkg;

  // source feeding one rms computation
  typedef enum logic [1:0] {
    SRC_HPF,
    SRC_FUND,
    SRC_SINC
  } mmc_src_t;

  // phase whose line period is measured
  typedef enum logic [1:0] {
    PH_A,
    PH_B,
    PH_C
  } mmc_phase_t;

  // decoded working configuration handed to the datapath
  typedef struct packed {
    logic             leak_hpf_en;
    logic             wave_src_leak;
    mmc_src_t [6:0]   rms_src;
    logic             refresh_long;
    logic             line_freq_60;
    logic             isum_vs_sum;
    mmc_phase_t       period_phase;
    logic             va_from_power;
    logic             sum_algebraic;
    logic             pulse_en;
  } mmc_cfg_t;

endpackage

//--- mmc_src_mux.sv
`timescale 1ns/1ns
`default_nettype none

// registered three-way source pick for one rms channel
module mmc_src_mux #(
  parameter int W = 24
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire mmc_pkg::mmc_src_t src,
  input  wire logic [W-1:0]      hpf,
  input  wire logic [W-1:0]      fund,
  input  wire logic [W-1:0]      sinc,
  output logic [W-1:0]           q
);
  import mmc_pkg::*;

  logic [W-1:0] next_q;  // selected sample

  // selection is combinational, the output is registered
  assign next_q = (src == SRC_FUND) ? fund :
                  (src == SRC_SINC) ? sinc : hpf;

  // output register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  property p_src_follow;
    @(posedge clk) disable iff (rst)
      (src == SRC_SINC) |=> (q == $past(sinc));
  endproperty
  a_src_follow: assert property (p_src_follow) else $error("rms source mux output wrong");

  property p_src_fund;
    @(posedge clk) disable iff (rst)
      (src == SRC_FUND) |=> (q == $past(fund));
  endproperty
  a_src_fund: assert property (p_src_fund) else $error("fundamental source not taken");

endmodule

`default_nettype wire

//--- mmc_mode_config_regs.sv
// Operation
// - leak bit 1 routes leakage through high-pass
// - wave bit picks normal or leakage waveform
// - rms selector: 00 hpf, 01 fundamental, 11 sinc
// - current selectors at 3:2 5:4 7:6 9:8
// - voltage selectors at 15:14 17:16 19:18
// - slow rms refresh 500ms, or 1000ms when set
// - frequency bit: 0 50Hz, 1 60Hz
// - isum compare: neutral rms or summed rms
// - period phase 00 A 01 B 10 C 11 A
// - apparent power from rms or power vector
// - totals: absolute sum or algebraic sum
// - energy pulses only when enable bit set
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "mmc_mode_map.svh"

module mmc_mode_config_regs #(
  parameter int REFRESH_SHORT_MS = `MMC_REFRESH_SHORT_MS,
  parameter int REFRESH_LONG_MS  = `MMC_REFRESH_LONG_MS
) (
  input  wire logic                clk,
  input  wire logic                rst,
  // avalon-mm slave, byte addressed
  input  wire logic [9:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  // datapath samples
  input  wire logic [23:0]         cur_wave_normal,
  input  wire logic [23:0]         leak_wave_raw,
  input  wire logic [23:0]         leak_wave_hpf,
  input  wire logic [6:0][23:0]    rms_in_hpf,
  input  wire logic [6:0][23:0]    rms_in_fund,
  input  wire logic [6:0][23:0]    rms_in_sinc,
  input  wire logic [23:0]         neutral_current_rms,
  input  wire logic [23:0]         phase_sum_rms,
  input  wire logic [2:0][23:0]    volt_wave,
  input  wire logic [2:0][23:0]    watt_phase,
  input  wire logic [2:0][23:0]    var_phase,
  input  wire logic [1:0]          pulse_req,
  // steered results
  output logic [23:0]              leak_wave,
  output logic [23:0]              cur_wave_out,
  output logic [6:0][23:0]         rms_in_sel,
  output logic [23:0]              isum_cmp_value,
  output logic [23:0]              period_wave,
  output logic [26:0]              watt_total,
  output logic [26:0]              var_total,
  output logic [1:0]               pulse_out,
  output logic                     rms_refresh_tick,
  output mmc_pkg::mmc_cfg_t        cfg
);
  import mmc_pkg::*;

  // refresh periods in clock cycles; kept as parameters so a bench can shorten them
  localparam int CYC_PER_MS  = `MMC_CLK_HZ / 1000;
  localparam int SHORT_CYC   = REFRESH_SHORT_MS * CYC_PER_MS;
  localparam int LONG_CYC    = REFRESH_LONG_MS * CYC_PER_MS;
  localparam int CNT_W       = 27;

  // bus handshake states
  typedef enum logic {
    AV_IDLE,
    AV_DONE
  } mmc_av_state_t;

  mmc_av_state_t av_state;       // current handshake state
  mmc_av_state_t next_av_state;  // following handshake state
  logic [23:0]   cfg_first;      // first configuration word
  logic [23:0]   cfg_second;     // second configuration word
  logic [23:0]   cfg_third;      // third configuration word
  logic [CNT_W-1:0] refresh_cnt; // cycles since the last refresh

  // ---------------- bus decode ----------------
  wire       req        = avs_read | avs_write;  // request pending
  wire [7:0] reg_idx    = avs_address[9:2];      // word index
  wire       hit_first  = (reg_idx == `MMC_IDX_CFG_FIRST);
  wire       hit_second = (reg_idx == `MMC_IDX_CFG_SECOND);
  wire       hit_third  = (reg_idx == `MMC_IDX_CFG_THIRD);
  wire       wr_take    = (av_state == AV_DONE) && avs_write;  // edge where a write lands
  // only the three low byte lanes carry register bits
  wire [23:0] lane_mask = {{8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
                           {8{avs_byteenable[0]}}};
  wire [23:0] rd_word   = hit_first  ? cfg_first  :
                          hit_second ? cfg_second :
                          hit_third  ? cfg_third  : 24'h000000;

  // merge a write into an old word, keeping reserved bits at zero
  function automatic logic [23:0] merge(input logic [23:0] old, input logic [23:0] wmask);
    merge = ((old & ~lane_mask) | (avs_writedata[23:0] & lane_mask)) & wmask;
  endfunction

  wire [23:0] next_first  = merge(cfg_first, `MMC_WMASK_FIRST);
  wire [23:0] next_second = merge(cfg_second, `MMC_WMASK_SECOND);
  wire [23:0] next_third  = merge(cfg_third, `MMC_WMASK_THIRD);

  // one wait cycle for every access, so the answer is always two edges in
  assign next_av_state   = (av_state == AV_IDLE && req) ? AV_DONE : AV_IDLE;
  assign avs_waitrequest = req && (av_state != AV_DONE);

  // handshake state
  always_ff @(posedge clk) begin
    if (rst) begin
      av_state <= AV_IDLE;
    end else begin
      av_state <= next_av_state;
    end
  end

  // read data is captured in the wait cycle and stands at the release edge
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (av_state == AV_IDLE && avs_read) begin
      avs_readdata <= {8'h00, rd_word};
    end
  end

  // configuration words; unmapped writes fall through untouched
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_first  <= `MMC_RST_CFG_FIRST;
      cfg_second <= `MMC_RST_CFG_SECOND;
      cfg_third  <= `MMC_RST_CFG_THIRD;
    end else if (wr_take) begin
      if (hit_first) begin
        cfg_first <= next_first;
      end
      if (hit_second) begin
        cfg_second <= next_second;
      end
      if (hit_third) begin
        cfg_third <= next_third;
      end
    end
  end

  // ---------------- field decode ----------------
  // code 10 is undefined; it falls back to the high-pass source
  function automatic mmc_src_t src_of(input logic [1:0] code);
    case (code)
      2'h1:    src_of = SRC_FUND;
      2'h3:    src_of = SRC_SINC;
      default: src_of = SRC_HPF;
    endcase
  endfunction

  // 11 repeats phase A, so only three results exist
  function automatic mmc_phase_t phase_of(input logic [1:0] code);
    case (code)
      2'h1:    phase_of = PH_B;
      2'h2:    phase_of = PH_C;
      default: phase_of = PH_A;
    endcase
  endfunction

  wire [1:0] sel_ic = cfg_second[`MMC_POS_SEL_IC +: 2];
  wire [1:0] sel_ib = cfg_second[`MMC_POS_SEL_IB +: 2];
  wire [1:0] sel_ia = cfg_second[`MMC_POS_SEL_IA +: 2];
  wire [1:0] sel_in = cfg_second[`MMC_POS_SEL_IN +: 2];
  wire [1:0] sel_va = cfg_second[`MMC_POS_SEL_VA +: 2];
  wire [1:0] sel_vb = cfg_second[`MMC_POS_SEL_VB +: 2];
  wire [1:0] sel_vc = cfg_second[`MMC_POS_SEL_VC +: 2];

  assign cfg.leak_hpf_en   = cfg_first[`MMC_BIT_LEAK_HPF];
  assign cfg.wave_src_leak = cfg_first[`MMC_BIT_WAVE_LEAK];
  // channel order: 0 ic, 1 ib, 2 ia, 3 in, 4 va, 5 vb, 6 vc
  assign cfg.rms_src       = '{src_of(sel_vc), src_of(sel_vb), src_of(sel_va),
                               src_of(sel_in), src_of(sel_ia), src_of(sel_ib),
                               src_of(sel_ic)};
  assign cfg.refresh_long  = cfg_second[`MMC_BIT_REFRESH];
  assign cfg.line_freq_60  = cfg_second[`MMC_BIT_FREQ];
  assign cfg.isum_vs_sum   = cfg_third[`MMC_BIT_ISUM_SEL];
  assign cfg.period_phase  = phase_of(cfg_third[`MMC_POS_PERIOD +: 2]);
  assign cfg.va_from_power = cfg_third[`MMC_BIT_APPARENT_POWER_METHOD_SELECT];
  assign cfg.sum_algebraic = cfg_third[`MMC_BIT_ADD_SEL];
  assign cfg.pulse_en      = cfg_third[`MMC_BIT_PULSE_EN];

  // ---------------- datapath steering ----------------
  // three-phase totals, absolute or signed
  function automatic logic [26:0] sum3(input logic [2:0][23:0] p, input logic alg);
    logic signed [26:0] acc;
    logic signed [26:0] e;
    acc = '0;
    for (int i = 0; i < 3; i++) begin
      e = 27'($signed(p[i]));
      if (!alg && e < 0) begin
        e = -e;
      end
      acc = acc + e;
    end
    sum3 = acc;
  endfunction

  wire [23:0] next_leak   = cfg.leak_hpf_en ? leak_wave_hpf : leak_wave_raw;
  wire [23:0] next_curw   = cfg.wave_src_leak ? next_leak : cur_wave_normal;
  wire [23:0] next_isum   = cfg.isum_vs_sum ? phase_sum_rms : neutral_current_rms;
  wire [23:0] next_period = (cfg.period_phase == PH_B) ? volt_wave[1] :
                            (cfg.period_phase == PH_C) ? volt_wave[2] : volt_wave[0];
  wire [1:0]  next_pulse  = cfg.pulse_en ? pulse_req : 2'h0;

  // steered waveform and value registers
  always_ff @(posedge clk) begin
    if (rst) begin
      leak_wave      <= 24'h000000;
      cur_wave_out   <= 24'h000000;
      isum_cmp_value <= 24'h000000;
      period_wave    <= 24'h000000;
      watt_total     <= 27'h0000000;
      var_total      <= 27'h0000000;
      pulse_out      <= 2'h0;
    end else begin
      leak_wave      <= next_leak;
      cur_wave_out   <= next_curw;
      isum_cmp_value <= next_isum;
      period_wave    <= next_period;
      watt_total     <= sum3(watt_phase, cfg.sum_algebraic);
      var_total      <= sum3(var_phase, cfg.sum_algebraic);
      pulse_out      <= next_pulse;
    end
  end

  // one registered source pick per rms channel
  for (genvar g = 0; g < 7; g++) begin : g_rms
    mmc_src_mux #(
      .W (24)
    ) u_mux (
      .clk  (clk),
      .rst  (rst),
      .src  (cfg.rms_src[g]),
      .hpf  (rms_in_hpf[g]),
      .fund (rms_in_fund[g]),
      .sinc (rms_in_sinc[g]),
      .q    (rms_in_sel[g])
    );
  end

  // ---------------- slow rms refresh ----------------
  // a period change takes effect at once; a count already past the new end restarts from zero at the next edge, with a tick
  wire [CNT_W-1:0] refresh_end = cfg.refresh_long ? CNT_W'(LONG_CYC - 1)
                                                  : CNT_W'(SHORT_CYC - 1);
  wire refresh_hit = (refresh_cnt >= refresh_end);

  // refresh divider and its one-cycle tick
  always_ff @(posedge clk) begin
    if (rst) begin
      refresh_cnt      <= '0;
      rms_refresh_tick <= 1'b0;
    end else begin
      refresh_cnt      <= refresh_hit ? '0 : refresh_cnt + 1'b1;
      rms_refresh_tick <= refresh_hit;
    end
  end

  // ---------------- checks ----------------
  sequence s_write_taken;
    avs_write && !avs_waitrequest;
  endsequence

  sequence s_read_taken;
    avs_read && !avs_waitrequest;
  endsequence

  property p_leak_route;
    @(posedge clk) disable iff (rst)
      1'b1 |=> leak_wave == ($past(cfg_first[22]) ? $past(leak_wave_hpf) : $past(leak_wave_raw));
  endproperty
  a_leak_route: assert property (p_leak_route) else $error("leak route wrong");

  property p_wave_src;
    @(posedge clk) disable iff (rst)
      !cfg_first[23] |=> cur_wave_out == $past(cur_wave_normal);
  endproperty
  a_wave_src: assert property (p_wave_src) else $error("waveform source wrong");

  property p_wave_leak;
    @(posedge clk) disable iff (rst)
      cfg_first[23] |=> cur_wave_out == ($past(cfg_first[22]) ? $past(leak_wave_hpf) : $past(leak_wave_raw));
  endproperty
  a_wave_leak: assert property (p_wave_leak) else $error("leakage waveform not output");

  property p_pulse_pass;
    @(posedge clk) disable iff (rst)
      cfg_third[9] |=> pulse_out == $past(pulse_req);
  endproperty
  a_pulse_pass: assert property (p_pulse_pass) else $error("pulse lost while enabled");

  property p_cur_fields;
    @(posedge clk) disable iff (rst)
      s_write_taken ##0 (hit_second && avs_byteenable[1:0] == 2'h3 && avs_writedata[7:6] == 2'h3)
        |=> cfg.rms_src[2] == SRC_SINC;
  endproperty
  a_cur_fields: assert property (p_cur_fields) else $error("phase a current selector");

  property p_volt_fields;
    @(posedge clk) disable iff (rst)
      s_write_taken ##0 (hit_second && avs_byteenable[2:1] == 2'h3 && avs_writedata[19:18] == 2'h1)
        |=> cfg.rms_src[6] == SRC_FUND;
  endproperty
  a_volt_fields: assert property (p_volt_fields) else $error("phase c voltage selector");

  property p_refresh_gap;
    @(posedge clk) disable iff (rst)
      rms_refresh_tick |=> !rms_refresh_tick [*8];
  endproperty
  a_refresh_gap: assert property (p_refresh_gap) else $error("refresh tick too soon");

  property p_isum_src;
    @(posedge clk) disable iff (rst)
      cfg_third[4] |=> isum_cmp_value == $past(phase_sum_rms);
  endproperty
  a_isum_src: assert property (p_isum_src) else $error("isum compare source wrong");

  property p_period_a;
    @(posedge clk) disable iff (rst)
      (cfg_third[6:5] == 2'h3) |=> period_wave == $past(volt_wave[0]);
  endproperty
  a_period_a: assert property (p_period_a) else $error("code 11 must pick phase a");

  property p_sum_abs;
    @(posedge clk) disable iff (rst)
      (!cfg_third[8] && !watt_phase[0][23] && !watt_phase[1][23] && !watt_phase[2][23])
        |=> watt_total == 27'($past(watt_phase[0])) + 27'($past(watt_phase[1]))
                          + 27'($past(watt_phase[2]));
  endproperty
  a_sum_abs: assert property (p_sum_abs) else $error("absolute total wrong");

  property p_pulse_gate;
    @(posedge clk) disable iff (rst)
      (pulse_out != 2'h0) |-> $past(cfg_third[9]);
  endproperty
  a_pulse_gate: assert property (p_pulse_gate) else $error("pulse while disabled");

  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
      s_read_taken ##0 hit_first |-> avs_readdata[21:0] == 22'h000000
                                     && avs_readdata[31:24] == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

endmodule

`default_nettype wire

//--- mmc_mode_config_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "mmc_mode_map.svh"

module mmc_mode_config_regs_tb;
  import mmc_pkg::*;
  localparam int LIMIT = 20000;                     // cycle ceiling, the run needs about 500
  localparam int POS[7] = '{2, 4, 6, 8, 14, 16, 18}; // selector low bit per rms channel

  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic [9:0]       avs_address = '0;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [31:0]      avs_writedata = '0;
  logic [3:0]       avs_byteenable = '0;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic [23:0]      cur_wave_normal = '0;
  logic [23:0]      leak_wave_raw = '0;
  logic [23:0]      leak_wave_hpf = '0;
  logic [6:0][23:0] rms_in_hpf = '0;
  logic [6:0][23:0] rms_in_fund = '0;
  logic [6:0][23:0] rms_in_sinc = '0;
  logic [23:0]      neutral_current_rms = '0;
  logic [23:0]      phase_sum_rms = '0;
  logic [2:0][23:0] volt_wave = '0;
  logic [2:0][23:0] watt_phase = '0;
  logic [2:0][23:0] var_phase = '0;
  logic [1:0]       pulse_req = '0;
  logic [23:0]      leak_wave;
  logic [23:0]      cur_wave_out;
  logic [6:0][23:0] rms_in_sel;
  logic [23:0]      isum_cmp_value;
  logic [23:0]      period_wave;
  logic [26:0]      watt_total;
  logic [26:0]      var_total;
  logic [1:0]       pulse_out;
  logic             rms_refresh_tick;
  mmc_cfg_t         cfg;
  int               bad_count = 0;       // mismatches seen
  int               samples_checked = 0; // comparisons made
  int               cycles = 0;          // timeout counter
  logic [23:0]      model [3];           // mirror of the three words
  logic [23:0]      wmask [3];           // writable bits per word
  logic [9:0]       addr [3];            // byte address per word
  logic [31:0]      rd;                  // last read data

  // smallest legal refresh periods; a tick cannot come inside this short run
  mmc_mode_config_regs #(.REFRESH_SHORT_MS(1), .REFRESH_LONG_MS(2)) mmc_mode_config_regs_inst (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cur_wave_normal(cur_wave_normal), .leak_wave_raw(leak_wave_raw),
    .leak_wave_hpf(leak_wave_hpf), .rms_in_hpf(rms_in_hpf), .rms_in_fund(rms_in_fund),
    .rms_in_sinc(rms_in_sinc), .neutral_current_rms(neutral_current_rms),
    .phase_sum_rms(phase_sum_rms), .volt_wave(volt_wave), .watt_phase(watt_phase),
    .var_phase(var_phase), .pulse_req(pulse_req), .leak_wave(leak_wave),
    .cur_wave_out(cur_wave_out), .rms_in_sel(rms_in_sel), .isum_cmp_value(isum_cmp_value),
    .period_wave(period_wave), .watt_total(watt_total), .var_total(var_total),
    .pulse_out(pulse_out), .rms_refresh_tick(rms_refresh_tick), .cfg(cfg));

  // free running clock
  always #5 clk = ~clk;

  // hang guard: a run past the ceiling counts as a failure
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      complete_run();
    end
  end

  task complete_run;
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [23:0] r24();
    logic [31:0] v;
    v = $urandom;
    return v[23:0];
  endfunction

  // rms source pick; undefined code 10 falls back to high-pass
  function automatic logic [23:0] pick(input logic [1:0] c, input logic [23:0] h, f, s);
    case (c)
      2'b01:   return f;
      2'b11:   return s;
      default: return h;
    endcase
  endfunction

  // three phase total, absolute or signed sum
  function automatic logic [26:0] total(input logic [2:0][23:0] p, input logic alg);
    logic signed [26:0] s;
    logic signed [26:0] v;
    s = '0;
    for (int k = 0; k < 3; k++) begin
      v = signed'(p[k]);
      if (!alg && v < 0) v = -v;
      s = s + v;
    end
    return s;
  endfunction

  // one avalon transfer; request held until waitrequest is seen low at an edge
  task bus(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    // waitrequest and readdata are read at the edge, before the edge updates them
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  // write one word and track which bits may change
  task reg_write(input int k, input logic [31:0] d, input logic [3:0] be);
    logic [23:0] m;
    bus(1'b1, addr[k], d, be);
    m = {{8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask[k];
    model[k] = (model[k] & ~m) | (d[23:0] & m);
  endtask

  task reg_read(input int k);
    bus(1'b0, addr[k], 32'h0, 4'hF);
    check(rd, {8'h00, model[k]}, "readback");
  endtask

  // new random datapath samples, launched at this edge
  task drive_rand;
    cur_wave_normal <= r24();
    leak_wave_raw <= r24();
    leak_wave_hpf <= r24();
    neutral_current_rms <= r24();
    phase_sum_rms <= r24();
    pulse_req <= 2'(r24());
    for (int i = 0; i < 7; i++) begin
      rms_in_hpf[i] <= r24();
      rms_in_fund[i] <= r24();
      rms_in_sinc[i] <= r24();
    end
    for (int i = 0; i < 3; i++) begin
      volt_wave[i] <= r24();
      watt_phase[i] <= r24();
      var_phase[i] <= r24();
    end
  endtask

  // each steered output must be the pick of the previous cycle's inputs
  task dp_check(input int n);
    logic [23:0] cn, lr, lh, nr, ps, lk;
    logic [6:0][23:0] h, f, s;
    logic [2:0][23:0] vw, wp, vp;
    logic [1:0] pr, c, ph;
    // let the write that just landed settle before looking at the decode
    #1;
    c = model[2][6:5];
    ph = (c == 2'b01) ? PH_B : (c == 2'b10) ? PH_C : PH_A;
    check(cfg.leak_hpf_en, model[0][22], "cfg leak");
    check(cfg.wave_src_leak, model[0][23], "cfg wave");
    check(cfg.refresh_long, model[1][22], "cfg refresh");
    check(cfg.line_freq_60, model[1][23], "cfg freq");
    check(cfg.isum_vs_sum, model[2][4], "cfg isum");
    check(cfg.period_phase, ph, "cfg period");
    check(cfg.va_from_power, model[2][7], "cfg va");
    check(cfg.sum_algebraic, model[2][8], "cfg sum");
    check(cfg.pulse_en, model[2][9], "cfg pulse");
    repeat (n) begin
      @(posedge clk);
      cn = cur_wave_normal; lr = leak_wave_raw; lh = leak_wave_hpf; pr = pulse_req;
      nr = neutral_current_rms; ps = phase_sum_rms; h = rms_in_hpf; f = rms_in_fund;
      s = rms_in_sinc; vw = volt_wave; wp = watt_phase; vp = var_phase;
      drive_rand();
      #1;
      lk = model[0][22] ? lh : lr;
      check(leak_wave, lk, "leak wave");
      check(cur_wave_out, model[0][23] ? lk : cn, "current wave");
      for (int i = 0; i < 7; i++)
        check(rms_in_sel[i], pick(model[1][POS[i] +: 2], h[i], f[i], s[i]), "rms pick");
      check(isum_cmp_value, model[2][4] ? ps : nr, "isum");
      check(period_wave, vw[(c == 2'b01) ? 1 : (c == 2'b10) ? 2 : 0], "period");
      check(watt_total, total(wp, model[2][8]), "watt total");
      check(var_total, total(vp, model[2][8]), "var total");
      check(pulse_out, pr & {2{model[2][9]}}, "pulse");
      check(rms_refresh_tick, 1'b0, "early tick");
    end
  endtask

  // main sequence
  initial begin
    logic [31:0] v;
    void'($urandom(32'h176f));
    wmask = '{`MMC_WMASK_FIRST, `MMC_WMASK_SECOND, `MMC_WMASK_THIRD};
    addr = '{{`MMC_IDX_CFG_FIRST, 2'b00}, {`MMC_IDX_CFG_SECOND, 2'b00},
             {`MMC_IDX_CFG_THIRD, 2'b00}};
    model = '{24'h0, 24'h0, 24'h0};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // reset values, then all ones: reserved bits must stay zero
    for (int k = 0; k < 3; k++) reg_read(k);
    for (int k = 0; k < 3; k++) reg_write(k, 32'hFFFF_FFFF, 4'hF);
    for (int k = 0; k < 3; k++) reg_read(k);
    dp_check(4);
    // middle lane only: the other lanes keep their bits
    for (int k = 0; k < 3; k++) reg_write(k, 32'h0, 4'b0010);
    for (int k = 0; k < 3; k++) reg_read(k);
    // unmapped neighbours answer, read zero and drop writes
    bus(1'b1, 10'h254, 32'hFFFF_FFFF, 4'hF);
    bus(1'b0, 10'h254, 32'h0, 4'hF);
    check(rd, 32'h0, "unmapped low");
    bus(1'b1, 10'h264, 32'hFFFF_FFFF, 4'hF);
    bus(1'b0, 10'h264, 32'h0, 4'hF);
    check(rd, 32'h0, "unmapped high");
    // every selector and period code in turn
    for (int c = 0; c < 4; c++) begin
      v = '0;
      for (int i = 0; i < 7; i++) v = v | (32'(c) << POS[i]);
      reg_write(1, v, 4'hF);
      reg_write(2, (32'(c) << 5) | 32'h390, 4'hF);
      dp_check(3);
    end
    // random words and lanes, back to back with datapath traffic
    for (int r = 0; r < 16; r++) begin
      for (int k = 0; k < 3; k++) reg_write(k, $urandom, (r < 4) ? 4'hF : 4'($urandom));
      dp_check(6);
      for (int k = 0; k < 3; k++) reg_read(k);
    end
    complete_run();
  end
endmodule

`default_nettype wire
